// ==== rtl/adcpi_pkg.sv ====
// constants and types shared by the parallel host interface of the adc
// assumes a single 250 MHz system clock and synchronous pin inputs
package adcpi_pkg;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int RES_W       = 12;
  localparam int BYTE_W      = 8;
  localparam int HI_W        = 4;
  localparam int HI_LSB      = 8;
  localparam int CFG_ACQ_BIT = 5;  // 0: internal acquisition, 1: external
  localparam int BIT_W       = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_NS  = 4;
  localparam int INT_OSC_NS  = 208;  // internal conversion clock period
  localparam int OSC_DIV     = INT_OSC_NS / SYS_CLK_NS;
  localparam int OSC_W       = 6;
  localparam int CNT_W       = 4;
  localparam int CONV_CLKS   = 13;   // conversion clocks per conversion
  localparam int ACQ_CLKS    = 4;    // internal acquisition clocks

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [BYTE_W-1:0] CFG_RST  = 8'h00;
  localparam logic [RES_W-1:0]  RES_RST  = 12'h000;
  localparam logic [HI_W-1:0]   HI_PAD   = 4'h0;

  typedef enum logic [1:0] {
    ADCPI_IDLE,
    ADCPI_ACQ_INT,
    ADCPI_ACQ_EXT,
    ADCPI_CONV
  } adcpi_state_t;

endpackage

// ==== rtl/adcpi_sar.sv ====
// successive-approximation register: one decision per conversion clock
// assumes start, step and finish are single-cycle strobes from the host
// interface controller, qualified by clk_en
`timescale 1ns/100ps

module adcpi_sar #(
  parameter int RES_W = adcpi_pkg::RES_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             finish,
  input  wire logic [RES_W-1:0] sample,
  output logic      [RES_W-1:0] result
);

  typedef struct packed {
    logic [RES_W-1:0]             held;
    logic [RES_W-1:0]             work;
    logic [adcpi_pkg::BIT_W-1:0]  bitpos;
    logic                         busy;
    logic [RES_W-1:0]             result;
  } adcpi_sar_t;

  adcpi_sar_t s_reg;
  adcpi_sar_t s_next;

  always_comb begin
    logic [RES_W-1:0] trial;
    trial  = s_reg.work | (RES_W'(1) << s_reg.bitpos);
    s_next = s_reg;
    if (start) begin
      s_next.held   = sample;
      s_next.work   = adcpi_pkg::RES_RST;
      s_next.bitpos = adcpi_pkg::BIT_W'(RES_W - 1);
      s_next.busy   = 1'b1;
    end else if (step && s_reg.busy) begin
      if (trial <= s_reg.held) begin
        s_next.work = trial;
      end
      if (s_reg.bitpos == '0) begin
        s_next.busy = 1'b0;
      end else begin
        s_next.bitpos = s_reg.bitpos - 1'b1;
      end
    end
    // result only moves at the end, so a read mid-conversion sees old data
    if (finish) begin
      s_next.result = s_next.work;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign result = s_reg.result;

endmodule

// ==== rtl/adcpi_top.sv ====
// parallel host interface of a 12-bit successive-approximation converter
// assumes all pins, the conversion clock pin included, are synchronous to
// clk; the data bus is split into input, output and output enable
`timescale 1ns/100ps

module adcpi_top #(
  parameter int CONV_CLKS = adcpi_pkg::CONV_CLKS,
  parameter int ACQ_CLKS  = adcpi_pkg::ACQ_CLKS,
  parameter int OSC_DIV   = adcpi_pkg::OSC_DIV
) (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         clk_en,
  input  wire logic                         chip_select_n,
  input  wire logic                         read_strobe_n,
  input  wire logic                         write_strobe_n,
  input  wire logic                         high_byte_select,
  input  wire logic [adcpi_pkg::BYTE_W-1:0] data_in,
  input  wire logic                         conv_clk_pin,
  input  wire logic                         clock_mode_ext,
  input  wire logic [adcpi_pkg::RES_W-1:0]  analog_sample,
  output logic      [adcpi_pkg::BYTE_W-1:0] data_out,
  output logic                              data_oe,
  output logic                              conversion_done_n,
  output logic      [adcpi_pkg::BYTE_W-1:0] config_byte
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    adcpi_pkg::adcpi_state_t          state;
    logic [adcpi_pkg::BYTE_W-1:0]     cfg;
    logic [adcpi_pkg::CNT_W-1:0]      cnt;
    logic [adcpi_pkg::OSC_W-1:0]      osc;
    logic                             pin_prev;
    logic                             rd_prev;
    logic                             wr_prev;
    logic                             reading;
    logic [adcpi_pkg::BYTE_W-1:0]     dout;
    logic                             oe;
    logic                             done_n;
  } adcpi_top_t;

  adcpi_top_t s_reg;
  adcpi_top_t s_next;

  logic                            rd_fall;
  logic                            wr_rise;
  logic                            tick;
  logic                            conv_start;
  logic                            conv_last;
  logic [adcpi_pkg::RES_W-1:0]     result;

  // byte lane of the result selected by high_byte_select
  function automatic logic [adcpi_pkg::BYTE_W-1:0] lane(
    input logic                        hi,
    input logic [adcpi_pkg::RES_W-1:0] r
  );
    if (hi) begin
      lane = {adcpi_pkg::HI_PAD,
              r[adcpi_pkg::HI_LSB +: adcpi_pkg::HI_W]};
    end else begin
      lane = r[adcpi_pkg::BYTE_W-1:0];
    end
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next     = s_reg;
    conv_start = 1'b0;
    conv_last  = 1'b0;
    rd_fall    = s_reg.rd_prev & ~read_strobe_n & ~chip_select_n;
    wr_rise    = ~s_reg.wr_prev & write_strobe_n & ~chip_select_n;
    // external clock counts its falling edges; internal clock is a divider
    if (clock_mode_ext) begin
      tick = s_reg.pin_prev & ~conv_clk_pin;
    end else begin
      tick = (s_reg.osc == adcpi_pkg::OSC_W'(OSC_DIV - 1));
    end
    s_next.pin_prev = conv_clk_pin;
    s_next.rd_prev  = read_strobe_n;
    s_next.wr_prev  = write_strobe_n;
    if (s_reg.osc == adcpi_pkg::OSC_W'(OSC_DIV - 1)) begin
      s_next.osc = '0;
    end else begin
      s_next.osc = s_reg.osc + 1'b1;
    end

    case (s_reg.state)
      adcpi_pkg::ADCPI_IDLE: begin
        if (wr_rise) begin
          s_next.cfg = data_in;
          s_next.cnt = '0;
          if (data_in[adcpi_pkg::CFG_ACQ_BIT]) begin
            s_next.state = adcpi_pkg::ADCPI_ACQ_EXT;
          end else begin
            s_next.state = adcpi_pkg::ADCPI_ACQ_INT;
          end
        end
      end
      adcpi_pkg::ADCPI_ACQ_INT: begin
        // a write pulse during this window is ignored; only ticks advance the count
        if (tick) begin
          if (s_reg.cnt == adcpi_pkg::CNT_W'(ACQ_CLKS - 1)) begin
            conv_start = 1'b1;
          end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
          end
        end
      end
      adcpi_pkg::ADCPI_ACQ_EXT: begin
        if (wr_rise) begin
          conv_start = 1'b1;
        end
      end
      adcpi_pkg::ADCPI_CONV: begin
        if (tick) begin
          if (s_reg.cnt == adcpi_pkg::CNT_W'(CONV_CLKS - 1)) begin
            conv_last    = 1'b1;
            s_next.state = adcpi_pkg::ADCPI_IDLE;
          end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
          end
        end
      end
      default: begin
        s_next.state = adcpi_pkg::ADCPI_IDLE;
      end
    endcase
    if (conv_start) begin
      s_next.state = adcpi_pkg::ADCPI_CONV;
      s_next.cnt   = '0;
    end

    if (rd_fall) begin
      s_next.reading = 1'b1;
    end else if (read_strobe_n || chip_select_n) begin
      s_next.reading = 1'b0;
    end
    s_next.oe   = s_next.reading;
    s_next.dout = lane(high_byte_select, result);

    if (rd_fall) begin
      s_next.done_n = 1'b1;
    end
    // a completion in the same cycle as a read fall is not lost
    if (conv_last) begin
      s_next.done_n = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg         <= '0;
      s_reg.state   <= adcpi_pkg::ADCPI_IDLE;
      s_reg.cfg     <= adcpi_pkg::CFG_RST;
      s_reg.rd_prev <= 1'b1;
      s_reg.wr_prev <= 1'b1;
      s_reg.done_n  <= 1'b1;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  adcpi_sar #(
    .RES_W (adcpi_pkg::RES_W)
  ) u_sar (
    .clk    (clk),
    .srst   (srst),
    .clk_en (clk_en),
    .start  (conv_start),
    .step   (tick && (s_reg.state == adcpi_pkg::ADCPI_CONV)),
    .finish (conv_last),
    .sample (analog_sample),
    .result (result)
  );

  assign data_out          = s_reg.dout;
  assign data_oe           = s_reg.oe;
  assign conversion_done_n = s_reg.done_n;
  assign config_byte       = s_reg.cfg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_hi_byte_lane: assert property (
    clk_en && high_byte_select |=> data_out ==
      {adcpi_pkg::HI_PAD,
       $past(result[adcpi_pkg::HI_LSB +: adcpi_pkg::HI_W])})
    else $error("high byte lane wrong");

  a_lo_byte_lane: assert property (
    clk_en && !high_byte_select |=>
      data_out == $past(result[adcpi_pkg::BYTE_W-1:0]))
    else $error("low byte lane wrong");

  a_done_on_finish: assert property (
    clk_en && conv_last |=>
      !conversion_done_n && result == $past(u_sar.s_next.result))
    else $error("done not asserted at conversion end");

  a_read_drives_bus: assert property (
    clk_en && rd_fall |=> data_oe)
    else $error("read fall did not enable bus");

  a_wr_int_start: assert property (
    clk_en && wr_rise && s_reg.state == adcpi_pkg::ADCPI_IDLE &&
    !data_in[adcpi_pkg::CFG_ACQ_BIT] |=>
      s_reg.state == adcpi_pkg::ADCPI_ACQ_INT &&
      config_byte == $past(data_in))
    else $error("config write did not start acquisition");

  a_wr_ext_conv: assert property (
    clk_en && wr_rise && s_reg.state == adcpi_pkg::ADCPI_ACQ_EXT |=>
      s_reg.state == adcpi_pkg::ADCPI_CONV && s_reg.cnt == '0)
    else $error("external acquisition not ended by write");

  a_read_clears: assert property (
    clk_en && rd_fall && !conv_last |=> conversion_done_n)
    else $error("read did not clear done");

  a_conv_length: assert property (
    s_reg.state == adcpi_pkg::ADCPI_CONV |->
      s_reg.cnt <= adcpi_pkg::CNT_W'(CONV_CLKS - 1))
    else $error("conversion ran past its clock count");

  a_cs_high_float: assert property (
    clk_en && chip_select_n |=> !data_oe)
    else $error("bus driven while deselected");

endmodule

// ==== sim/adcpi_host.sv ====
// host model: microprocessor strobes, configuration writes, byte reads
// assumes all pins are sampled by the device on the rising edge of clk
`timescale 1ns/100ps

module adcpi_host (
  input  wire logic       clk,
  input  wire logic       ext_clk_mode,
  input  wire logic [7:0] bus,
  output logic            chip_select_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            high_byte_select,
  output logic [7:0]      host_data,
  output logic            conv_clk_pin
);
  logic [2:0] div_reg;
  logic       driving;
  logic [7:0] rd_data;

  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    high_byte_select = 1'b0;
    host_data = 8'h5A;
    driving = 1'b0;
    div_reg = 3'h0;
    conv_clk_pin = 1'b0;
    rd_data = 8'h00;
  end

  // ****************************************
  // conversion clock pin and released bus
  // ****************************************
  // static low in internal clock mode, eight system clocks otherwise
  always @(posedge clk) begin
    div_reg <= div_reg + 3'h1;
    conv_clk_pin <= ext_clk_mode & div_reg[2];
  end

  // undriven lines must not hold the last value
  always @(posedge clk) begin
    if (!driving) begin
      host_data <= ~host_data;
    end
  end

  // ****************************************
  // bus cycles
  // ****************************************
  task automatic write_cfg(input logic [7:0] cfg);
    @(posedge clk);
    #1;
    chip_select_n = 1'b0;
    write_strobe_n = 1'b0;
    driving = 1'b1;
    host_data = cfg;
    repeat (2) @(posedge clk);
    #1;
    write_strobe_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    // select stays low two clocks past the write rise, so the rise is sampled while selected
    chip_select_n = 1'b1;
    driving = 1'b0;
  endtask

  // waits for done before calling, high byte then low byte
  task automatic read_start(input logic hi, input logic cs_off);
    @(posedge clk);
    #1;
    chip_select_n = cs_off;
    high_byte_select = hi;
    @(posedge clk);
    #1;
    read_strobe_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    // bus has settled well after the edge that enabled it
    rd_data = bus;
  endtask

  task automatic read_stop;
    read_strobe_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chip_select_n = 1'b1;
  endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the adc parallel host interface
// assumes the host model drives pins; bench drives sample and modes
`timescale 1ns/100ps

module tb_top;
  localparam int OSC_DIV_T = 4;
  logic        clk;
  logic        srst;
  logic        clk_en;
  logic        clock_mode_ext;
  logic [11:0] analog_sample;
  logic [11:0] samp;
  logic [7:0]  cfg;
  logic [7:0]  data_out;
  logic [7:0]  config_byte;
  logic [7:0]  host_data;
  logic        data_oe;
  logic        conversion_done_n;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic        hbs;
  logic        cclk;
  wire  [7:0]  bus_lvl = data_oe ? data_out : host_data;
  int          miscompares;
  int          tests_run;
  int          seed;
  int          n;
  int          per;

  adcpi_host host_u (.clk(clk), .ext_clk_mode(clock_mode_ext),
    .bus(bus_lvl), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .high_byte_select(hbs),
    .host_data(host_data), .conv_clk_pin(cclk));

  adcpi_top #(.OSC_DIV(OSC_DIV_T)) dut_u (.clk(clk), .srst(srst),
    .clk_en(clk_en), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .high_byte_select(hbs), .data_in(bus_lvl),
    .conv_clk_pin(cclk), .clock_mode_ext(clock_mode_ext),
    .analog_sample(analog_sample), .data_out(data_out),
    .data_oe(data_oe), .conversion_done_n(conversion_done_n),
    .config_byte(config_byte));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic check(input string name, input logic [11:0] exp,
                       input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [11:0] exp_byte(input logic hi,
                                           input logic [11:0] s);
    return hi ? {4'h0, adcpi_pkg::HI_PAD, s[11:8]} : {4'h0, s[7:0]};
  endfunction

  task automatic read_and_check(input logic hi);
    host_u.read_start(hi, 1'b0);
    check("read_byte", exp_byte(hi, samp), {4'h0, host_u.rd_data});
    check("read_oe", 12'h001, {11'h000, data_oe});
    check("done_cleared", 12'h001, {11'h000, conversion_done_n});
    host_u.read_stop;
    @(posedge clk);
    #1;
    check("oe_released", 12'h000, {11'h000, data_oe});
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    end_sim;
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 68;
    miscompares = 0;
    tests_run = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    clock_mode_ext = 1'b0;
    analog_sample = 12'h000;
    repeat (3) @(posedge clk);
    #1;
    srst = 1'b0;
    check("done_rst", 12'h001, {11'h000, conversion_done_n});
    check("cfg_rst", {4'h0, adcpi_pkg::CFG_RST},
          {4'h0, config_byte});
    host_u.read_start(1'b1, 1'b1);
    check("oe_cs_high", 12'h000, {11'h000, data_oe});
    host_u.read_stop;
    for (int i = 0; i < 8; i++) begin
      clock_mode_ext = i[0];
      samp = 12'($random(seed));
      cfg = 8'($random(seed));
      if (i < 2) samp = i[0] ? 12'hFFF : 12'h000;
      cfg[adcpi_pkg::CFG_ACQ_BIT] = i[1];
      analog_sample = samp;
      per = clock_mode_ext ? 8 : OSC_DIV_T;
      host_u.write_cfg(cfg);
      check("cfg_latched", {4'h0, cfg}, {4'h0, config_byte});
      if (cfg[adcpi_pkg::CFG_ACQ_BIT]) begin
        repeat (120) @(posedge clk);
        #1;
        check("ext_wait", 12'h001, {11'h000, conversion_done_n});
        host_u.write_cfg(~cfg);
        check("cfg_kept", {4'h0, cfg}, {4'h0, config_byte});
      end
      n = 0;
      while (conversion_done_n !== 1'b0 && n < 500) begin
        @(posedge clk);
        #1;
        n++;
      end
      check("done_low", 12'h000, {11'h000, conversion_done_n});
      if (cfg[adcpi_pkg::CFG_ACQ_BIT]) begin
        check("conv_len", 12'h001,
              {11'h000, n >= 12 * per - 4 && n <= 13 * per + 4});
      end
      read_and_check(1'b1);
      read_and_check(1'b0);
    end
    // with the enable low a full write must leave no trace
    clk_en = 1'b0;
    host_u.write_cfg(~cfg);
    check("cfg_frozen", {4'h0, cfg}, {4'h0, config_byte});
    clk_en = 1'b1;
    // reset in mid-run while a result is pending
    cfg[adcpi_pkg::CFG_ACQ_BIT] = 1'b0;
    host_u.write_cfg(cfg);
    repeat (170) @(posedge clk);
    #1;
    check("done_pend", 12'h000, {11'h000, conversion_done_n});
    srst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    srst = 1'b0;
    check("done_rst2", 12'h001, {11'h000, conversion_done_n});
    check("cfg_rst2", {4'h0, adcpi_pkg::CFG_RST},
          {4'h0, config_byte});
    @(posedge clk);
    #1;
    check("oe_rst2", 12'h000, {11'h000, data_oe});
    end_sim;
  end
endmodule
